// ==== dma_cfg_pkg.sv ====
// Purpose: constants for the dma controller status and setup front end
// Assumes: axi4-lite register access, 32-bit data, one aligned word per register
// Notes: offsets are full bus byte addresses; only bits 11:2 select the word
`default_nettype none
package dma_cfg_pkg;
    localparam logic [31:0] STATUS_OFFSET     = 32'h40800000;
    localparam logic [31:0] SETUP_OFFSET      = 32'h40800004;
    localparam logic [31:0] BASE_OFFSET       = 32'h40800008;
    localparam int          ADDR_DECODE_LSB   = 2;
    localparam int          ADDR_DECODE_MSB   = 11;
    localparam int          TEST_MSB          = 31;
    localparam int          TEST_LSB          = 28;
    localparam logic [3:0]  TEST_PRESENT      = 4'h1;
    localparam logic [3:0]  TEST_ABSENT       = 4'h0;
    localparam int          CHAN_MSB          = 20;
    localparam int          CHAN_LSB          = 16;
    localparam logic [4:0]  CHANNEL_COUNT_LESS_ONE = 5'h02;
    localparam int          PHASE_MSB         = 7;
    localparam int          PHASE_LSB         = 4;
    localparam int          ENABLE_BIT        = 0;
    localparam int          PROT_MSB          = 7;
    localparam int          PROT_LSB          = 5;
    localparam int          BASE_LSB          = 7;
    localparam logic [24:0] BASE_RESET        = 25'h0;
    localparam logic [2:0]  PROT_RESET        = 3'h0;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;
    localparam logic [3:0]  PHASE_LAST        = 4'ha;

    typedef enum logic [3:0] {
        PH_IDLE      = 4'b0000,
        PH_RD_CTRL   = 4'b0001,
        PH_RD_SRCEND = 4'b0010,
        PH_RD_DSTEND = 4'b0011,
        PH_RD_SRC    = 4'b0100,
        PH_WR_DST    = 4'b0101,
        PH_WR_REQCLR = 4'b0110,
        PH_WR_CTRL   = 4'b0111,
        PH_STALLED   = 4'b1000,
        PH_DONE      = 4'b1001,
        PH_SG_TRANS  = 4'b1010
    } phase_t;

    // word index of a byte address within the block
    function automatic logic [9:0] word_index(input logic [31:0] addr);
        word_index = addr[ADDR_DECODE_MSB:ADDR_DECODE_LSB];
    endfunction : word_index
endpackage : dma_cfg_pkg
`default_nettype wire

// ==== dma_controller_config_status.sv ====
// Purpose: axi4-lite register front end of a three-channel dma controller
// Assumes: one clock, asynchronous active-low reset, sequencer supplies its phase
// Notes: software must keep the base pointer inside on-chip sram
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dma_controller_config_status #(
    parameter bit TEST_LOGIC_PRESENT = 1'b1
) (
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic [31:0] AWADDR,
    input  wire logic [2:0]  AWPROT,
    input  wire logic        AWVALID,
    output var  logic        AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output var  logic        WREADY,
    output var  logic [1:0]  BRESP,
    output var  logic        BVALID,
    input  wire logic        BREADY,
    input  wire logic [31:0] ARADDR,
    input  wire logic [2:0]  ARPROT,
    input  wire logic        ARVALID,
    output var  logic        ARREADY,
    output var  logic [31:0] RDATA,
    output var  logic [1:0]  RRESP,
    output var  logic        RVALID,
    input  wire logic        RREADY,
    input  wire logic [3:0]  SEQ_PHASE,
    output var  logic        CTRL_ENABLE,
    output var  logic [3:1]  HPROT_LEVEL,
    output var  logic [31:0] PRIMARY_BASE
);
    logic        aw_held_reg;
    logic [31:0] aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        do_write;
    logic        setup_we;
    logic        base_we;
    logic        write_hit;
    logic        enable_reg;
    logic [2:0]  prot_reg;
    logic [24:0] base_reg;
    logic [3:0]  phase_seen;
    logic [31:0] status_word;
    logic [31:0] rd_next;
    logic [1:0]  rresp_next;

    // address and data may arrive in either order; each is held until both
    assign AWREADY  = !aw_held_reg && !BVALID;
    assign WREADY   = !w_held_reg && !BVALID;
    assign do_write = aw_held_reg && w_held_reg && !BVALID;

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 32'h0;
        end
        else if (AWVALID && AWREADY)
        begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= AWADDR;
        end
        else if (do_write)
            aw_held_reg <= 1'b0;
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end
        else if (WVALID && WREADY)
        begin
            w_held_reg <= 1'b1;
            w_data_reg <= WDATA;
            w_strb_reg <= WSTRB;
        end
        else if (do_write)
            w_held_reg <= 1'b0;
    end

    // write decode; the status word has no write path at all
    always_comb
    begin
        setup_we  = do_write && (dma_cfg_pkg::word_index(aw_addr_reg)
                    == dma_cfg_pkg::word_index(dma_cfg_pkg::SETUP_OFFSET));
        base_we   = do_write && (dma_cfg_pkg::word_index(aw_addr_reg)
                    == dma_cfg_pkg::word_index(dma_cfg_pkg::BASE_OFFSET));
        write_hit = setup_we || base_we;
    end

    // write response; a status or unmapped write gets slverr, nothing changes
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            BVALID <= 1'b0;
            BRESP  <= dma_cfg_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            BVALID <= 1'b1;
            BRESP  <= write_hit ? dma_cfg_pkg::RESP_OKAY : dma_cfg_pkg::RESP_SLVERR;
        end
        else if (BREADY)
            BVALID <= 1'b0;
    end

    dma_setup_regs u_setup (
        .clock      (CLOCK),
        .rst_n      (RST_N),
        .setup_we   (setup_we),
        .base_we    (base_we),
        .wdata      (w_data_reg),
        .wstrb      (w_strb_reg),
        .enable_reg (enable_reg),
        .prot_reg   (prot_reg),
        .base_reg   (base_reg)
    );

    dma_phase_sync u_phase (
        .clock     (CLOCK),
        .rst_n     (RST_N),
        .phase_in  (SEQ_PHASE),
        .phase_out (phase_seen)
    );

    // outputs toward the memory master and the sequencer
    assign CTRL_ENABLE  = enable_reg;
    assign HPROT_LEVEL  = prot_reg;
    assign PRIMARY_BASE = {base_reg, 7'h00};

    // status word; undefined fields read zero
    always_comb
    begin
        status_word = 32'h0;
        status_word[dma_cfg_pkg::TEST_MSB:dma_cfg_pkg::TEST_LSB] =
            TEST_LOGIC_PRESENT ? dma_cfg_pkg::TEST_PRESENT : dma_cfg_pkg::TEST_ABSENT;
        status_word[dma_cfg_pkg::CHAN_MSB:dma_cfg_pkg::CHAN_LSB] =
            dma_cfg_pkg::CHANNEL_COUNT_LESS_ONE;
        status_word[dma_cfg_pkg::PHASE_MSB:dma_cfg_pkg::PHASE_LSB] = phase_seen;
        status_word[dma_cfg_pkg::ENABLE_BIT] = enable_reg;
    end

    // read mux; setup word is write-only so it reads zero with slverr
    always_comb
    begin
        rd_next    = 32'h0;
        rresp_next = dma_cfg_pkg::RESP_OKAY;
        if (dma_cfg_pkg::word_index(ARADDR) == dma_cfg_pkg::word_index(dma_cfg_pkg::STATUS_OFFSET))
            rd_next = status_word;
        else if (dma_cfg_pkg::word_index(ARADDR) == dma_cfg_pkg::word_index(dma_cfg_pkg::BASE_OFFSET))
            rd_next = {base_reg, 7'h00};
        else
            rresp_next = dma_cfg_pkg::RESP_SLVERR;
    end

    assign ARREADY = !RVALID;

    // read data registered; one read under way at a time
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RVALID <= 1'b0;
            RDATA  <= 32'h0;
            RRESP  <= dma_cfg_pkg::RESP_OKAY;
        end
        else if (ARVALID && ARREADY)
        begin
            RVALID <= 1'b1;
            RDATA  <= rd_next;
            RRESP  <= rresp_next;
        end
        else if (RREADY)
            RVALID <= 1'b0;
    end

    property p_status_fixed;
        @(posedge CLOCK) disable iff (!RST_N)
        (ARVALID && ARREADY && ARADDR[11:2] == 10'h000)
            |=> (RDATA[20:16] == 5'h02 && RDATA[31:28] == (TEST_LOGIC_PRESENT ? 4'h1 : 4'h0));
    endproperty
    a_status_fixed: assert property (p_status_fixed) else $error("status fixed fields wrong");

    property p_chan_field;
        @(posedge CLOCK) disable iff (!RST_N)
        RVALID && RRESP == 2'h0 && $past(ARADDR[11:2]) == 10'h000 && $past(ARVALID && ARREADY)
            |-> RDATA[20:16] == 5'h02;
    endproperty
    a_chan_field: assert property (p_chan_field) else $error("channel count wrong");

    property p_phase_shown;
        @(posedge CLOCK) disable iff (!RST_N)
        (SEQ_PHASE <= 4'ha) |=> (phase_seen == $past(SEQ_PHASE));
    endproperty
    a_phase_shown: assert property (p_phase_shown) else $error("phase not tracked");

    property p_enable_status;
        @(posedge CLOCK) disable iff (!RST_N)
        (ARVALID && ARREADY && ARADDR[11:2] == 10'h000) |=> (RDATA[0] == $past(CTRL_ENABLE));
    endproperty
    a_enable_status: assert property (p_enable_status) else $error("enable status mismatch");

    property p_prot_write;
        @(posedge CLOCK) disable iff (!RST_N)
        (setup_we && w_strb_reg[0]) |=> (HPROT_LEVEL == $past(w_data_reg[7:5]));
    endproperty
    a_prot_write: assert property (p_prot_write) else $error("protection levels not taken");

    property p_prot_hold;
        @(posedge CLOCK) disable iff (!RST_N)
        !setup_we |=> $stable(HPROT_LEVEL);
    endproperty
    a_prot_hold: assert property (p_prot_hold) else $error("protection moved without write");

    property p_enable_write;
        @(posedge CLOCK) disable iff (!RST_N)
        (setup_we && w_strb_reg[0]) |=> (CTRL_ENABLE == $past(w_data_reg[0]) && BVALID);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not taken");

    property p_base_low_zero;
        @(posedge CLOCK) disable iff (!RST_N)
        (base_we && w_strb_reg == 4'hf) |=> (PRIMARY_BASE == {$past(w_data_reg[31:7]), 7'h00});
    endproperty
    a_base_low_zero: assert property (p_base_low_zero) else $error("base pointer wrong");

    property p_status_write_inert;
        @(posedge CLOCK) disable iff (!RST_N)
        (do_write && !write_hit) |=> ($stable(CTRL_ENABLE) && $stable(PRIMARY_BASE) && BRESP == 2'h2);
    endproperty
    a_status_write_inert: assert property (p_status_write_inert) else $error("status write had effect");

    // undefined phase codes are shown as idle one cycle later
    property p_phase_clamp;
        @(posedge CLOCK) disable iff (!RST_N)
        (SEQ_PHASE > 4'ha) |=> (phase_seen == 4'h0);
    endproperty
    a_phase_clamp: assert property (p_phase_clamp) else $error("undefined phase shown");

    property p_status_phase_read;
        @(posedge CLOCK) disable iff (!RST_N)
        (ARVALID && ARREADY && ARADDR[11:2] == 10'h000) |=> (RDATA[7:4] == $past(phase_seen));
    endproperty
    a_status_phase_read: assert property (p_status_phase_read) else $error("phase read wrong");

    property p_enable_hold;
        @(posedge CLOCK) disable iff (!RST_N)
        !setup_we |=> $stable(CTRL_ENABLE);
    endproperty
    a_enable_hold: assert property (p_enable_hold) else $error("enable moved without write");

    property p_setup_read_refused;
        @(posedge CLOCK) disable iff (!RST_N)
        (ARVALID && ARREADY && ARADDR[11:2] == 10'h001) |=> (RDATA == 32'h0 && RRESP == 2'h2);
    endproperty
    a_setup_read_refused: assert property (p_setup_read_refused) else $error("setup read not refused");

    property p_base_read;
        @(posedge CLOCK) disable iff (!RST_N)
        (ARVALID && ARREADY && ARADDR[11:2] == 10'h002) |=> (RDATA == $past(PRIMARY_BASE) && RRESP == 2'h0);
    endproperty
    a_base_read: assert property (p_base_read) else $error("base read wrong");

    property p_base_hold;
        @(posedge CLOCK) disable iff (!RST_N)
        !base_we |=> $stable(PRIMARY_BASE);
    endproperty
    a_base_hold: assert property (p_base_hold) else $error("base moved without write");

    property p_write_ok;
        @(posedge CLOCK) disable iff (!RST_N)
        (do_write && write_hit) |=> (BVALID && BRESP == 2'h0);
    endproperty
    a_write_ok: assert property (p_write_ok) else $error("mapped write not accepted");

    property p_status_spare_zero;
        @(posedge CLOCK) disable iff (!RST_N)
        (ARVALID && ARREADY && ARADDR[11:2] == 10'h000)
            |=> (RRESP == 2'h0 && RDATA[27:21] == 7'h00 && RDATA[15:8] == 8'h00 && RDATA[3:1] == 3'h0);
    endproperty
    a_status_spare_zero: assert property (p_status_spare_zero) else $error("status spare bits set");

    c_enable_set: cover property (@(posedge CLOCK) disable iff (!RST_N) $rose(CTRL_ENABLE));
    c_base_write: cover property (@(posedge CLOCK) disable iff (!RST_N) base_we);
    c_status_read: cover property (@(posedge CLOCK) disable iff (!RST_N)
        RVALID && RREADY && RDATA[20:16] == 5'h02);
    c_write_order: cover property (@(posedge CLOCK) disable iff (!RST_N) w_held_reg && !aw_held_reg);
    c_status_write: cover property (@(posedge CLOCK) disable iff (!RST_N)
        do_write && !write_hit);
endmodule : dma_controller_config_status
`default_nettype wire

// ==== dma_phase_sync.sv ====
// Purpose: registers the sequencer phase code for the status word
// Assumes: phase input from the sequencer on the same clock
// Notes: illegal codes above the last one are shown as idle
`timescale 1ns/1ps
`default_nettype none
module dma_phase_sync (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [3:0] phase_in,
    output var  logic [3:0] phase_out
);
    // clamp undefined codes so software never sees garbage
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            phase_out <= dma_cfg_pkg::PH_IDLE;
        else if (phase_in > dma_cfg_pkg::PHASE_LAST)
            phase_out <= dma_cfg_pkg::PH_IDLE;
        else
            phase_out <= phase_in;
    end
endmodule : dma_phase_sync
`default_nettype wire

// ==== dma_setup_regs.sv ====
// Purpose: holds enable, protection levels and structure base pointer
// Assumes: single-cycle write strobes from the bus slave
// Notes: setup word is write-only, base pointer keeps bits 31:7
`timescale 1ns/1ps
`default_nettype none
module dma_setup_regs (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        setup_we,
    input  wire logic        base_we,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output var  logic        enable_reg,
    output var  logic [2:0]  prot_reg,
    output var  logic [24:0] base_reg
);
    // enable and protection from the low byte; bits 4:1 are dropped
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_reg <= 1'b0;
            prot_reg   <= dma_cfg_pkg::PROT_RESET;
        end
        else if (setup_we && wstrb[0])
        begin
            enable_reg <= wdata[dma_cfg_pkg::ENABLE_BIT];
            prot_reg   <= wdata[dma_cfg_pkg::PROT_MSB:dma_cfg_pkg::PROT_LSB];
        end
    end

    // base pointer, byte lanes honoured; low seven bits never stored
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            base_reg <= dma_cfg_pkg::BASE_RESET;
        else if (base_we)
        begin
            if (wstrb[0]) base_reg[0]     <= wdata[7];
            if (wstrb[1]) base_reg[8:1]   <= wdata[15:8];
            if (wstrb[2]) base_reg[16:9]  <= wdata[23:16];
            if (wstrb[3]) base_reg[24:17] <= wdata[31:24];
        end
    end
endmodule : dma_setup_regs
`default_nettype wire

// ==== seq_phase_model.sv ====
// Purpose: sequencer phase source standing beside the dma front end
// Assumes: bench asks for a phase code with a one-cycle load strobe
// Notes: phase holds until the next load while enabled, as a stalled sequencer would; disabled it returns to idle
`timescale 1ns/1ps
`default_nettype none
module seq_phase_model (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       load,
    input  wire logic [3:0] code,
    input  wire logic       ctrl_enable,
    output var  logic [3:0] phase
);
    // a disabled controller never leaves idle, so no kinder than the real one
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            phase <= 4'h0;
        else if (!ctrl_enable)
            phase <= 4'h0;
        else if (load)
            phase <= code;
    end
endmodule : seq_phase_model
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: self-checking bench for the dma status and setup front end
// Assumes: axi4-lite master tasks, bready and rready held high throughout
// Notes: random data from an lfsr with a fixed start value
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [31:0] SRAM_BASE = 32'h20000000; // plain default, region of the on-chip sram
    localparam logic [31:0] UNMAPPED  = 32'h4080000c;
    logic        clock, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, ctrl_enable, ph_load;
    logic [31:0] awaddr, wdata, araddr, rdata, primary_base, lfsr, d, e, q;
    logic [3:0]  wstrb, seq_phase, ph_code;
    logic [1:0]  bresp, rresp, r;
    logic [2:0]  hprot_level;
    int          fail_count, compares;

    dma_controller_config_status i_dma_controller_config_status (.CLOCK(clock), .RST_N(rst_n),
        .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .SEQ_PHASE(seq_phase),
        .CTRL_ENABLE(ctrl_enable), .HPROT_LEVEL(hprot_level), .PRIMARY_BASE(primary_base));
    seq_phase_model i_seq_phase_model (.clock(clock), .rst_n(rst_n), .load(ph_load), .code(ph_code),
        .ctrl_enable(ctrl_enable), .phase(seq_phase));

    // free-running 25 mhz clock
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        lfsr_next = x[31] ? ({x[30:0], 1'b0} ^ 32'h04c11db7) : {x[30:0], 1'b0};
    endfunction : lfsr_next

    // illegal phase codes are shown as idle
    function automatic logic [31:0] exp_status(input logic [3:0] ph, input logic en);
        exp_status = {4'h1, 7'h00, 5'h02, 8'h00, (ph > 4'ha) ? 4'h0 : ph, 3'h0, en};
    endfunction : exp_status

    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        if (fail_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // address and data offered together, each dropped at its own handshake
    task automatic axi_write(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s,
                             output logic [1:0] resp);
        bit aw_ok;
        bit w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        resp = 2'h3;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= s;
        wvalid <= 1'b1;
        forever
        begin
            @(posedge clock);
            if (!aw_ok && awready === 1'b1)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1)
            begin
                resp = bresp;
                break;
            end
        end
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
        bit ar_ok;
        ar_ok = 1'b0;
        resp = 2'h3;
        v = 32'hx;
        araddr <= a;
        arvalid <= 1'b1;
        forever
        begin
            @(posedge clock);
            if (!ar_ok && arready === 1'b1)
            begin
                ar_ok = 1'b1;
                arvalid <= 1'b0;
            end
            else if (rvalid === 1'b1)
            begin
                v = rdata;
                resp = rresp;
                break;
            end
        end
    endtask : axi_read

    // hang guard, far beyond the few hundred cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge clock);
        fail_count++;
        test_done();
    end

    // main sequence
    initial
    begin
        {rst_n, awvalid, wvalid, arvalid, ph_load} = 5'h00;
        {bready, rready} = 2'h3;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'h0;
        ph_code = 4'h0;
        fail_count = 0;
        compares = 0;
        lfsr = 32'hdc69dc78;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check(34'(primary_base), 34'h0);
        check(34'({ctrl_enable, hprot_level}), 34'h0);
        axi_read(dma_cfg_pkg::BASE_OFFSET, q, r);
        check({r, q}, {dma_cfg_pkg::RESP_OKAY, 32'h0});
        axi_read(dma_cfg_pkg::STATUS_OFFSET, q, r);
        check({r, q}, {dma_cfg_pkg::RESP_OKAY, exp_status(4'h0, 1'b0)});
        // setup word: corners first, then random, bits 4:1 kept zero
        for (int i = 0; i < 7; i++)
        begin
            lfsr = lfsr_next(lfsr);
            d = (i == 0) ? 32'h000000e1 : (i == 1) ? 32'h0 : (lfsr & 32'hffffffe1);
            axi_write(dma_cfg_pkg::SETUP_OFFSET, d, 4'hf, r);
            check(34'(r), 34'(dma_cfg_pkg::RESP_OKAY));
            check(34'(ctrl_enable), 34'(d[0]));
            check(34'(hprot_level), 34'(d[7:5]));
            axi_read(dma_cfg_pkg::SETUP_OFFSET, q, r);
            check({r, q}, {dma_cfg_pkg::RESP_SLVERR, 32'h0});
            axi_read(dma_cfg_pkg::STATUS_OFFSET, q, r);
            check({r, q}, {dma_cfg_pkg::RESP_OKAY, exp_status(4'h0, d[0])});
        end
        axi_write(dma_cfg_pkg::SETUP_OFFSET, 32'h1, 4'hf, r);
        // lowest lane not strobed: enable and protection keep their values
        axi_write(dma_cfg_pkg::SETUP_OFFSET, 32'h000000e0, 4'he, r);
        check(34'({ctrl_enable, hprot_level}), 34'h8);
        // every phase code, the undefined ones too
        for (int c = 0; c < 16; c++)
        begin
            ph_code <= 4'(c);
            ph_load <= 1'b1;
            @(posedge clock);
            ph_load <= 1'b0;
            repeat (3) @(posedge clock);
            axi_read(dma_cfg_pkg::STATUS_OFFSET, q, r);
            check({r, q}, {dma_cfg_pkg::RESP_OKAY, exp_status(4'(c), 1'b1)});
        end
        // base pointer kept inside sram before any transfer
        for (int i = 0; i < 6; i++)
        begin
            lfsr = lfsr_next(lfsr);
            d = SRAM_BASE | (lfsr & 32'h0000ff80);
            axi_write(dma_cfg_pkg::BASE_OFFSET, d, 4'hf, r);
            check(34'(r), 34'(dma_cfg_pkg::RESP_OKAY));
            axi_read(dma_cfg_pkg::BASE_OFFSET, q, r);
            check({r, q}, {dma_cfg_pkg::RESP_OKAY, d});
            check(34'(primary_base), 34'(d));
        end
        // upper lanes only: lower half must survive
        e = ~d & 32'hffffff80;
        axi_write(dma_cfg_pkg::BASE_OFFSET, e, 4'hc, r);
        d = {e[31:16], d[15:0]};
        axi_read(dma_cfg_pkg::BASE_OFFSET, q, r);
        check({r, q}, {dma_cfg_pkg::RESP_OKAY, d});
        // status is read-only, a write changes nothing
        axi_write(dma_cfg_pkg::STATUS_OFFSET, 32'hffffffff, 4'hf, r);
        check(34'(r), 34'(dma_cfg_pkg::RESP_SLVERR));
        axi_read(dma_cfg_pkg::STATUS_OFFSET, q, r);
        check({r, q}, {dma_cfg_pkg::RESP_OKAY, exp_status(4'hf, 1'b1)});
        // unmapped word refused both ways, base untouched
        axi_write(UNMAPPED, 32'h0, 4'hf, r);
        check(34'(r), 34'(dma_cfg_pkg::RESP_SLVERR));
        axi_read(UNMAPPED, q, r);
        check({r, q}, {dma_cfg_pkg::RESP_SLVERR, 32'h0});
        check(34'(primary_base), 34'(d));
        // reset in mid-run clears enable, protection and base at once
        rst_n <= 1'b0;
        @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check(34'(primary_base), 34'h0);
        check(34'({ctrl_enable, hprot_level}), 34'h0);
        axi_read(dma_cfg_pkg::STATUS_OFFSET, q, r);
        check({r, q}, {dma_cfg_pkg::RESP_OKAY, exp_status(4'h0, 1'b0)});
        test_done();
    end
endmodule : tb_top
`default_nettype wire
